// *** hdl/pcc_defines.svh ***
// Register indices, field positions, reset values and timing counts.
// Included by the controller and the bench; defines only, no logic.
`ifndef PCC_DEFINES_SVH
`define PCC_DEFINES_SVH

// Register indices; byte address is four times the index
`define PCC_IDX_CTRL      4'h0
`define PCC_IDX_ASTART_FQ 4'h1
`define PCC_IDX_ASTOP_FQ  4'h2
`define PCC_IDX_START_DLY 4'h3
`define PCC_IDX_STOP_DLY  4'h4
`define PCC_IDX_SLEEP_FQ  4'h5
`define PCC_IDX_SLEEP_DLY 4'h6
`define PCC_IDX_WAKE_LVL  4'h7
`define PCC_IDX_COMP_COEF 4'h8
`define PCC_IDX_LIM_RT    4'h9
`define PCC_IDX_RT_UNIT   4'hA
`define PCC_IDX_CO_FQ     4'hB
`define PCC_IDX_STATUS    4'hC
`define PCC_IDX_IRQ_STAT  4'hD
`define PCC_IDX_IRQ_CLR   4'hE
`define PCC_IDX_IRQ_EN    4'hF
`define PCC_NUM_CFG       12

// Writable bits of each config register, index order
`define PCC_CFG_MASKS '{16'h0073, 16'hFFFF, 16'hFFFF, 16'h01FF, \
   16'h01FF, 16'hFFFF, 16'h0FFF, 16'h3FFF, 16'h7FFF, 16'h0FFF, \
   16'h00FF, 16'hFFFF}
`define PCC_CFG_RST       16'h0000

// Control register fields
`define PCC_CTRL_ENABLE   0
`define PCC_CTRL_COMP_FB  1
`define PCC_CTRL_CNT_LO   4
`define PCC_CTRL_CNT_HI   6

// Time base
`define PCC_CLK_NS        8
`define PCC_TICK_S        1
`define PCC_NS_PER_S      1000000000
`define PCC_SEC_PER_MIN   6'h3C
`define PCC_MIN_PER_HOUR  6'h3C
`define PCC_UNIT_MINUTES  8'h96

`define PCC_NUM_PUMPS     5
`define PCC_RESP_OKAY     2'h0
`define PCC_RESP_SLVERR   2'h2

`endif

// *** hdl/pcc_pkg.sv ***
// Types shared by the pump cascade controller modules.
// Constants live in pcc_defines.svh.
package pcc_pkg;

   typedef enum logic [1:0]
   {
      PCC_OFF   = 2'b00,
      PCC_RUN   = 2'b01,
      PCC_SLEEP = 2'b10
   } pcc_mode_t;

   typedef struct packed
   {
      logic fault;
      logic changeover;
      logic wake;
      logic sleep;
      logic destage;
      logic stage;
   } pcc_evt_t;

endpackage

// *** hdl/pcc_timer_if.sv ***
// Carrier between the controller and its delay timers.
// One instance per timer; controller drives run, tick and limit.
`timescale 1ns/1ps
interface pcc_timer_if;
   logic run;
   logic tick;
   logic [11:0] limit;
   logic done;
   modport ctl (output run, output tick, output limit, input done);
   modport tmr (input run, input tick, input limit, output done);
endinterface

// *** hdl/pcc_delay_timer.sv ***
// Seconds delay timer: done while run has held for limit ticks.
// Assumes tick is a one-cycle pulse once per second.
`timescale 1ns/1ps
module pcc_delay_timer
   import pcc_pkg::*;
(
   input wire logic clk_in,      // System clock
   input wire logic sys_rst_in,  // Async reset, high
   input wire logic ce_in,       // Clock enable
   pcc_timer_if.tmr t            // Control and result
);
   logic [11:0] cnt_q;
   logic [11:0] cnt_d;

   // Dropping run restarts the count from zero
   always_comb
   begin
      cnt_d = cnt_q;
      if (!t.run)
         cnt_d = 12'h000;
      else if (t.tick && cnt_q != 12'hFFF)
         cnt_d = cnt_q + 12'h001;
   end

   always_ff @(posedge clk_in or posedge sys_rst_in)
   begin
      if (sys_rst_in)
         cnt_q <= 12'h000;
      else if (ce_in)
         cnt_q <= cnt_d;
   end

   assign t.done = t.run && (cnt_q >= t.limit);

   a_no_early_done: assert property (
      @(posedge clk_in) disable iff (sys_rst_in)
      $rose(t.run) && t.limit != 12'h000 && cnt_q == 12'h000 |-> !t.done)
      else $error("timer done before its delay");
endmodule

// *** hdl/pcc_cascade_ctrl.sv ***
// Pump cascade controller: staging, sleep/wake, changeover, AXI4-Lite.
// Assumes frequency and pressure inputs are synchronous to clk_in.
`timescale 1ns/1ps
`include "pcc_defines.svh"
module pcc_cascade_ctrl
   import pcc_pkg::*;
#(
   parameter int unsigned SEC_CYCLES =
      `PCC_TICK_S * `PCC_NS_PER_S / `PCC_CLK_NS
)
(
   input wire logic clk_in,                  // 125 MHz clock
   input wire logic sys_rst_in,              // Async reset, high
   input wire logic ce_in,                   // Clock enable
   input wire logic [7:0] s_axi_awaddr_in,   // Write address
   input wire logic s_axi_awvalid_in,        // Write address valid
   output logic s_axi_awready_out,           // Write address ready
   input wire logic [31:0] s_axi_wdata_in,   // Write data
   input wire logic [3:0] s_axi_wstrb_in,    // Write strobes
   input wire logic s_axi_wvalid_in,         // Write data valid
   output logic s_axi_wready_out,            // Write data ready
   output logic [1:0] s_axi_bresp_out,       // Write response
   output logic s_axi_bvalid_out,            // Write response valid
   input wire logic s_axi_bready_in,         // Write response ready
   input wire logic [7:0] s_axi_araddr_in,   // Read address
   input wire logic s_axi_arvalid_in,        // Read address valid
   output logic s_axi_arready_out,           // Read address ready
   output logic [31:0] s_axi_rdata_out,      // Read data
   output logic [1:0] s_axi_rresp_out,       // Read response
   output logic s_axi_rvalid_out,            // Read data valid
   input wire logic s_axi_rready_in,         // Read data ready
   input wire logic [15:0] output_frequency_in,    // Drive freq, 0.1 Hz
   input wire logic [15:0] pressure_reference_in,  // PID reference
   input wire logic [15:0] pressure_feedback_in,   // PID feedback
   input wire logic drive_run_enable_in,     // Run enable pin
   input wire logic [4:0] pump_ready_in,     // Pump 1..5 ready pins
   output logic [4:0] pump_command_out,      // Pump 1..5 commands
   output logic [15:0] comp_pressure_out,    // Compensated pressure
   output logic asleep_out,                  // Installation asleep
   output logic irq_out                      // Interrupt, level high
);
   localparam logic [15:0] CFG_MASK [`PCC_NUM_CFG] = `PCC_CFG_MASKS;

   // Pin synchronisers, three stages, filtered on stages two and three
   logic [5:0] s1_q, s2_q, s3_q, pin_q, pin_d;
   always_comb
   begin
      pin_d = (s2_q == s3_q) ? s3_q : pin_q;
   end
   always_ff @(posedge clk_in or posedge sys_rst_in)
   begin
      if (sys_rst_in)
      begin
         s1_q <= 6'h00;
         s2_q <= 6'h00;
         s3_q <= 6'h00;
         pin_q <= 6'h00;
      end
      else if (ce_in)
      begin
         s1_q <= {drive_run_enable_in, pump_ready_in};
         s2_q <= s1_q;
         s3_q <= s2_q;
         pin_q <= pin_d;
      end
   end
   wire logic [4:0] rdy = pin_q[4:0];
   wire logic run_pin = pin_q[5];

   // Time base: seconds, minutes, hours
   logic [26:0] pre_q, pre_d;
   logic [5:0] min_q, min_d, hr_q, hr_d;
   logic sec_tick, min_tick, hr_tick;
   always_comb
   begin
      sec_tick = (pre_q == 27'(SEC_CYCLES - 1));
      min_tick = sec_tick && (min_q == `PCC_SEC_PER_MIN - 6'h01);
      hr_tick = min_tick && (hr_q == `PCC_MIN_PER_HOUR - 6'h01);
      pre_d = sec_tick ? 27'h0 : pre_q + 27'h1;
      min_d = min_tick ? 6'h00 : (sec_tick ? min_q + 6'h01 : min_q);
      hr_d = hr_tick ? 6'h00 : (min_tick ? hr_q + 6'h01 : hr_q);
   end
   always_ff @(posedge clk_in or posedge sys_rst_in)
   begin
      if (sys_rst_in)
      begin
         pre_q <= 27'h0;
         min_q <= 6'h00;
         hr_q <= 6'h00;
      end
      else if (ce_in)
      begin
         pre_q <= pre_d;
         min_q <= min_d;
         hr_q <= hr_d;
      end
   end

   // Bus slave and register file
   logic [15:0] cfg_q [`PCC_NUM_CFG];
   logic [15:0] cfg_d [`PCC_NUM_CFG];
   logic aw_hold_q, aw_hold_d, w_hold_q, w_hold_d, bvalid_q, bvalid_d;
   logic awready_q, awready_d, wready_q, wready_d, arready_q, arready_d;
   logic rvalid_q, rvalid_d;
   logic [7:0] awaddr_q, awaddr_d;
   logic [31:0] wdata_q, wdata_d, rdata_q, rdata_d;
   logic [3:0] wstrb_q, wstrb_d;
   logic [1:0] bresp_q, bresp_d, rresp_q, rresp_d;
   pcc_evt_t ist_q, ist_d, ien_q, ien_d, evt;
   logic irq_q, irq_d, do_wr;
   logic [31:0] status_w;
   logic [3:0] widx, ridx;

   always_comb
   begin
      do_wr = aw_hold_q && w_hold_q && !bvalid_q;
      widx = awaddr_q[5:2];
      ridx = s_axi_araddr_in[5:2];
      aw_hold_d = aw_hold_q;
      w_hold_d = w_hold_q;
      awaddr_d = awaddr_q;
      wdata_d = wdata_q;
      wstrb_d = wstrb_q;
      if (s_axi_awvalid_in && awready_q)
      begin
         aw_hold_d = 1'b1;
         awaddr_d = s_axi_awaddr_in;
      end
      if (s_axi_wvalid_in && wready_q)
      begin
         w_hold_d = 1'b1;
         wdata_d = s_axi_wdata_in;
         wstrb_d = s_axi_wstrb_in;
      end
      if (do_wr)
      begin
         aw_hold_d = 1'b0;
         w_hold_d = 1'b0;
      end
      awready_d = !aw_hold_d;
      wready_d = !w_hold_d;
      bvalid_d = do_wr || (bvalid_q && !s_axi_bready_in);
      bresp_d = bresp_q;
      cfg_d = cfg_q;
      ien_d = ien_q;
      ist_d = (ist_q & ~pcc_evt_t'(0)) | evt;
      if (do_wr)
      begin
         bresp_d = (awaddr_q[7:6] == 2'h0) ? `PCC_RESP_OKAY : `PCC_RESP_SLVERR;
         if (awaddr_q[7:6] == 2'h0)
         begin
            if (widx < 4'(`PCC_NUM_CFG))
            begin
               if (wstrb_q[0])
                  cfg_d[widx][7:0] = wdata_q[7:0] & CFG_MASK[widx][7:0];
               if (wstrb_q[1])
                  cfg_d[widx][15:8] = wdata_q[15:8] & CFG_MASK[widx][15:8];
            end
            else if (widx == `PCC_IDX_IRQ_EN && wstrb_q[0])
               ien_d = pcc_evt_t'(wdata_q[5:0]);
            else if (widx == `PCC_IDX_IRQ_CLR && wstrb_q[0])
               ist_d = (ist_q & ~pcc_evt_t'(wdata_q[5:0])) | evt;
         end
      end
      irq_d = |(ist_d & ien_d);
      // Read side
      arready_d = arready_q;
      rvalid_d = rvalid_q && !s_axi_rready_in;
      rdata_d = rdata_q;
      rresp_d = rresp_q;
      if (s_axi_arvalid_in && arready_q)
      begin
         rvalid_d = 1'b1;
         rresp_d = `PCC_RESP_OKAY;
         rdata_d = 32'h0;
         if (s_axi_araddr_in[7:6] != 2'h0)
            rresp_d = `PCC_RESP_SLVERR;
         else if (ridx < 4'(`PCC_NUM_CFG))
            rdata_d = {16'h0, cfg_q[ridx]};
         else if (ridx == `PCC_IDX_STATUS)
            rdata_d = status_w;
         else if (ridx == `PCC_IDX_IRQ_STAT)
            rdata_d = {26'h0, ist_q};
         else if (ridx == `PCC_IDX_IRQ_EN)
            rdata_d = {26'h0, ien_q};
      end
      arready_d = !rvalid_d;
   end

   always_ff @(posedge clk_in or posedge sys_rst_in)
   begin
      if (sys_rst_in)
      begin
         aw_hold_q <= 1'b0;
         w_hold_q <= 1'b0;
         awready_q <= 1'b0;
         wready_q <= 1'b0;
         arready_q <= 1'b0;
         bvalid_q <= 1'b0;
         rvalid_q <= 1'b0;
         awaddr_q <= 8'h00;
         wdata_q <= 32'h0;
         wstrb_q <= 4'h0;
         rdata_q <= 32'h0;
         bresp_q <= 2'h0;
         rresp_q <= 2'h0;
         ist_q <= '0;
         ien_q <= '0;
         irq_q <= 1'b0;
         for (int i = 0; i < `PCC_NUM_CFG; i++)
            cfg_q[i] <= `PCC_CFG_RST;
      end
      else if (ce_in)
      begin
         aw_hold_q <= aw_hold_d;
         w_hold_q <= w_hold_d;
         awready_q <= awready_d;
         wready_q <= wready_d;
         arready_q <= arready_d;
         bvalid_q <= bvalid_d;
         rvalid_q <= rvalid_d;
         awaddr_q <= awaddr_d;
         wdata_q <= wdata_d;
         wstrb_q <= wstrb_d;
         rdata_q <= rdata_d;
         bresp_q <= bresp_d;
         rresp_q <= rresp_d;
         ist_q <= ist_d;
         ien_q <= ien_d;
         irq_q <= irq_d;
         cfg_q <= cfg_d;
      end
   end

   wire logic [15:0] ctrl = cfg_q[`PCC_IDX_CTRL];
   wire logic [15:0] freq = output_frequency_in;

   // Delay timers
   pcc_timer_if t_start ();
   pcc_timer_if t_stop ();
   pcc_timer_if t_sleep ();
   pcc_delay_timer u_start (.clk_in(clk_in), .sys_rst_in(sys_rst_in),
      .ce_in(ce_in), .t(t_start));
   pcc_delay_timer u_stop (.clk_in(clk_in), .sys_rst_in(sys_rst_in),
      .ce_in(ce_in), .t(t_stop));
   pcc_delay_timer u_sleep (.clk_in(clk_in), .sys_rst_in(sys_rst_in),
      .ce_in(ce_in), .t(t_sleep));

   // Cascade control
   pcc_mode_t mode_q, mode_d;
   logic [4:0] aux_q, aux_d, cmd_q, cmd_d, avail, free, var_oh;
   logic [2:0] var_q, var_d, nxt;
   logic [11:0] rt_q, rt_d;
   logic [15:0] comp_q, comp_d, base;
   logic act_q, act_d, found, var_fault, co_ok, chg, start_go, stop_go;
   logic unit_tick, asleep_q, asleep_d;
   logic [30:0] prod;
   logic [16:0] sum;
   logic [3:0] cand;

   always_comb
   begin
      for (int i = 0; i < `PCC_NUM_PUMPS; i++)
         avail[i] = rdy[i] && (3'(i) < ctrl[`PCC_CTRL_CNT_HI:`PCC_CTRL_CNT_LO]);
      var_oh = 5'h01 << var_q;
      free = avail & ~aux_q & ~var_oh;
      // Next ready pump after the variable one, skipping aux pumps
      found = 1'b0;
      nxt = var_q;
      for (int k = `PCC_NUM_PUMPS - 1; k >= 1; k--)
      begin
         cand = {1'b0, var_q} + 4'(k);
         if (cand >= 4'(`PCC_NUM_PUMPS))
            cand = cand - 4'(`PCC_NUM_PUMPS);
         if (avail[cand[2:0]] && !aux_q[cand[2:0]])
         begin
            found = 1'b1;
            nxt = cand[2:0];
         end
      end
      unit_tick = (cfg_q[`PCC_IDX_RT_UNIT][7:0] == `PCC_UNIT_MINUTES) ?
         min_tick : hr_tick;
      var_fault = (mode_q != PCC_OFF) && !avail[var_q];
      co_ok = (cfg_q[`PCC_IDX_LIM_RT] != 16'h0) &&
         (rt_q >= cfg_q[`PCC_IDX_LIM_RT][11:0]) &&
         ((cfg_q[`PCC_IDX_CO_FQ] == 16'h0) ? (mode_q == PCC_SLEEP) :
         (mode_q == PCC_RUN && freq < cfg_q[`PCC_IDX_CO_FQ]));
      chg = (var_fault || co_ok) && found;
      // Timers restart after any step, so each step needs a fresh delay
      t_start.run = (mode_q == PCC_RUN) && !act_q && (|free) &&
         (freq > cfg_q[`PCC_IDX_ASTART_FQ]);
      t_stop.run = (mode_q == PCC_RUN) && !act_q && (|aux_q) &&
         (freq < cfg_q[`PCC_IDX_ASTOP_FQ]);
      t_sleep.run = (mode_q == PCC_RUN) && !act_q &&
         (freq < cfg_q[`PCC_IDX_SLEEP_FQ]);
      t_start.tick = sec_tick;
      t_stop.tick = sec_tick;
      t_sleep.tick = sec_tick;
      t_start.limit = {3'h0, cfg_q[`PCC_IDX_START_DLY][8:0]};
      t_stop.limit = {3'h0, cfg_q[`PCC_IDX_STOP_DLY][8:0]};
      t_sleep.limit = cfg_q[`PCC_IDX_SLEEP_DLY][11:0];
      start_go = t_start.done && !chg && !t_sleep.done;
      stop_go = t_stop.done && !chg && !t_sleep.done && !start_go;
      evt = '0;
      mode_d = mode_q;
      unique case (mode_q)
         PCC_OFF: if (ctrl[`PCC_CTRL_ENABLE] && run_pin) mode_d = PCC_RUN;
         PCC_RUN: if (t_sleep.done) mode_d = PCC_SLEEP;
         PCC_SLEEP:
            if (pressure_feedback_in < cfg_q[`PCC_IDX_WAKE_LVL])
               mode_d = PCC_RUN;
         default: mode_d = PCC_OFF;
      endcase
      if (!(ctrl[`PCC_CTRL_ENABLE] && run_pin))
         mode_d = PCC_OFF;
      evt.sleep = (mode_q == PCC_RUN) && (mode_d == PCC_SLEEP);
      evt.wake = (mode_q == PCC_SLEEP) && (mode_d == PCC_RUN);
      aux_d = aux_q & avail;
      if (start_go)
         aux_d = aux_d | (free & (~free + 5'h01));
      if (stop_go)
         for (int i = 0; i < `PCC_NUM_PUMPS; i++)
            if (aux_q[i] && (aux_q >> (i + 1)) == 5'h00)
               aux_d[i] = 1'b0;
      if (mode_d != PCC_RUN)
         aux_d = 5'h00;
      var_d = chg ? nxt : var_q;
      rt_d = rt_q;
      if (chg)
         rt_d = 12'h000;
      else if (mode_q == PCC_RUN && avail[var_q] && unit_tick &&
         rt_q != 12'hFFF)
         rt_d = rt_q + 12'h001;
      evt.stage = start_go;
      evt.destage = stop_go;
      evt.changeover = chg;
      evt.fault = |(cmd_q & ~avail);
      act_d = start_go || stop_go || chg || t_sleep.done;
      cmd_d = (aux_d | ((mode_d == PCC_RUN) ? (5'h01 << var_d) : 5'h00)) &
         avail;
      // Head-loss offset grows with speed, scaled by coefficient / 2^15
      base = ctrl[`PCC_CTRL_COMP_FB] ? pressure_feedback_in :
         pressure_reference_in;
      prod = cfg_q[`PCC_IDX_COMP_COEF][14:0] * freq;
      sum = {1'b0, base} + {1'b0, prod[30:15]};
      comp_d = sum[16] ? 16'hFFFF : sum[15:0];
      asleep_d = (mode_d == PCC_SLEEP);
   end

   always_ff @(posedge clk_in or posedge sys_rst_in)
   begin
      if (sys_rst_in)
      begin
         mode_q <= PCC_OFF;
         aux_q <= 5'h00;
         cmd_q <= 5'h00;
         var_q <= 3'h0;
         rt_q <= 12'h000;
         act_q <= 1'b0;
         comp_q <= 16'h0000;
         asleep_q <= 1'b0;
      end
      else if (ce_in)
      begin
         mode_q <= mode_d;
         aux_q <= aux_d;
         cmd_q <= cmd_d;
         var_q <= var_d;
         rt_q <= rt_d;
         act_q <= act_d;
         comp_q <= comp_d;
         asleep_q <= asleep_d;
      end
   end

   assign status_w = {17'h0, run_pin, mode_q == PCC_SLEEP, var_q, rdy, cmd_q};
   assign s_axi_awready_out = awready_q;
   assign s_axi_wready_out = wready_q;
   assign s_axi_bresp_out = bresp_q;
   assign s_axi_bvalid_out = bvalid_q;
   assign s_axi_arready_out = arready_q;
   assign s_axi_rdata_out = rdata_q;
   assign s_axi_rresp_out = rresp_q;
   assign s_axi_rvalid_out = rvalid_q;
   assign pump_command_out = cmd_q;
   assign comp_pressure_out = comp_q;
   assign asleep_out = asleep_q;
   assign irq_out = irq_q;

   sequence s_wake_cond;
      mode_q == PCC_SLEEP && ce_in && ctrl[`PCC_CTRL_ENABLE] && run_pin &&
         pressure_feedback_in < cfg_q[`PCC_IDX_WAKE_LVL];
   endsequence

   a_wake_on_level: assert property (
      @(posedge clk_in) disable iff (sys_rst_in)
      s_wake_cond |=> mode_q == PCC_RUN && cmd_q[var_q] == avail[var_q])
      else $error("no wake at wake level");
   a_cmd_ready_only: assert property (
      @(posedge clk_in) disable iff (sys_rst_in)
      $past(ce_in) |-> (cmd_q & ~$past(avail)) == 5'h00)
      else $error("non-ready pump commanded");
   a_stage_one_more: assert property (
      @(posedge clk_in) disable iff (sys_rst_in)
      ce_in && start_go && mode_d == PCC_RUN |=>
      $countones(aux_q) == $countones($past(aux_q) & $past(avail)) + 1)
      else $error("start did not add one pump");
   a_destage_one: assert property (
      @(posedge clk_in) disable iff (sys_rst_in)
      ce_in && stop_go && mode_d == PCC_RUN && (aux_q & ~avail) == 5'h00 |=>
      $countones(aux_q) == $countones($past(aux_q)) - 1)
      else $error("stop did not remove one pump");
   a_sleep_enter: assert property (
      @(posedge clk_in) disable iff (sys_rst_in)
      ce_in && t_sleep.done && ctrl[`PCC_CTRL_ENABLE] && run_pin |=>
      asleep_out && aux_q == 5'h00)
      else $error("sleep not entered after delay");
   a_sleep_timing: assert property (
      @(posedge clk_in) disable iff (sys_rst_in)
      mode_q == PCC_RUN && !act_q && freq < cfg_q[`PCC_IDX_SLEEP_FQ] &&
      cfg_q[`PCC_IDX_SLEEP_DLY] == 16'h0 |-> t_sleep.done)
      else $error("sleep delay not running");
   a_change_gated: assert property (
      @(posedge clk_in) disable iff (sys_rst_in)
      $past(ce_in) && var_q != $past(var_q) |->
      $past(co_ok) || $past(var_fault))
      else $error("changeover without permission");
   a_minute_count: assert property (
      @(posedge clk_in) disable iff (sys_rst_in)
      ce_in && !chg && hr_tick == 1'b0 && min_tick && mode_q == PCC_RUN &&
      avail[var_q] && rt_q != 12'hFFF &&
      cfg_q[`PCC_IDX_RT_UNIT][7:0] != `PCC_UNIT_MINUTES |=> $stable(rt_q))
      else $error("hour base counted a minute");
   a_comp_zero: assert property (
      @(posedge clk_in) disable iff (sys_rst_in)
      ce_in && cfg_q[`PCC_IDX_COMP_COEF] == 16'h0 |=> comp_q == $past(base))
      else $error("zero coefficient changed pressure");
   a_irq_level: assert property (
      @(posedge clk_in) disable iff (sys_rst_in)
      $past(ce_in) |-> irq_out == |(ist_q & ien_q))
      else $error("interrupt level mismatch");
endmodule

// *** tb/pcc_pump_model.sv ***
// Pump side: status contacts of five pumps.
// Assumes the bench sets the fault pattern between phases.
`timescale 1ns/1ps
module pcc_pump_model
(
   input wire logic [4:0] cmd_in,   // Pump commands
   input wire logic [4:0] fault_in, // Faulted or disabled pumps
   output logic [4:0] ready_out,    // Status contacts
   output logic bad_out             // A faulted pump is commanded
);
   // Contacts ignore the command: a stopped pump still reports ready
   assign ready_out = ~fault_in;
   // Settles low once the controller has dropped the faulted pump
   assign bad_out = |(cmd_in & fault_in);
endmodule

// *** tb/pump_cascade_controller_bench.sv ***
// Bench for the pump cascade controller over AXI4-Lite.
// Assumes a one-second tick of 10 clocks to keep delays short.
`timescale 1ns/1ps
`include "pcc_defines.svh"
module pump_cascade_controller_bench;
   import pcc_pkg::*;
   logic clk_in = 0, sys_rst_in = 1, ce_in = 1;
   logic [7:0] s_axi_awaddr_in = 0, s_axi_araddr_in = 0;
   logic s_axi_awvalid_in = 0, s_axi_wvalid_in = 0, s_axi_bready_in = 1;
   logic s_axi_arvalid_in = 0, s_axi_rready_in = 1;
   logic [31:0] s_axi_wdata_in = 0, s_axi_rdata_out, d;
   logic [3:0] s_axi_wstrb_in = 4'hF;
   logic s_axi_awready_out, s_axi_wready_out, s_axi_bvalid_out;
   logic s_axi_arready_out, s_axi_rvalid_out, asleep_out, irq_out;
   logic [1:0] s_axi_bresp_out, s_axi_rresp_out, r;
   logic [15:0] output_frequency_in = 0, pressure_reference_in = 16'h03E8;
   logic [15:0] pressure_feedback_in = 16'h03E8, comp_pressure_out;
   logic [15:0] cp = 16'h03E8;
   logic drive_run_enable_in = 0;
   logic [4:0] pump_ready_in, pump_command_out, fault = 0;
   logic bad;
   int n_errors = 0, cmp_count = 0, cyc = 0;
   localparam logic [15:0] M [12] = `PCC_CFG_MASKS;
   localparam logic [7:0] A [13] = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h10,
      8'h14, 8'h18, 8'h1C, 8'h20, 8'h24, 8'h28, 8'h2C, 8'h3C};
   localparam logic [15:0] C [13] = '{16'h0031, 16'h0064, 16'h0032,
      16'h0001, 16'h0001, 16'h001E, 16'h0003, 16'h01F4, 16'h0000,
      16'h0000, 16'h0096, 16'h0064, 16'h0001};

   pcc_cascade_ctrl #(.SEC_CYCLES(10)) i_dut (.clk_in, .sys_rst_in, .ce_in,
      .s_axi_awaddr_in, .s_axi_awvalid_in, .s_axi_awready_out,
      .s_axi_wdata_in, .s_axi_wstrb_in, .s_axi_wvalid_in, .s_axi_wready_out,
      .s_axi_bresp_out, .s_axi_bvalid_out, .s_axi_bready_in,
      .s_axi_araddr_in, .s_axi_arvalid_in, .s_axi_arready_out,
      .s_axi_rdata_out, .s_axi_rresp_out, .s_axi_rvalid_out,
      .s_axi_rready_in, .output_frequency_in, .pressure_reference_in,
      .pressure_feedback_in, .drive_run_enable_in, .pump_ready_in,
      .pump_command_out, .comp_pressure_out, .asleep_out, .irq_out);
   pcc_pump_model i_pumps (.cmd_in(pump_command_out), .fault_in(fault),
      .ready_out(pump_ready_in), .bad_out(bad));

   always #4 clk_in = ~clk_in;

   task results;
      if (n_errors == 0 && cmp_count > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask

   // Cycle ceiling well above the several hundred the tests need
   always @(posedge clk_in)
   begin
      cyc <= cyc + 1;
      if (cyc == 20000)
      begin
         n_errors++;
         results();
      end
   end

   task chk(input logic [31:0] s, input logic [31:0] e);
      cmp_count++;
      if (s !== e)
      begin
         n_errors++;
         $display("wrong value at %0t: %h not %h", $time, s, e);
      end
   endtask

   // Ready lines are held high, so each response is taken on arrival
   task wr(input logic [7:0] a, input logic [31:0] v);
      logic ad, wd;
      ad = 0;
      wd = 0;
      s_axi_awaddr_in <= a;
      s_axi_wdata_in <= v;
      s_axi_awvalid_in <= 1;
      s_axi_wvalid_in <= 1;
      while (!(ad && wd))
      begin
         @(posedge clk_in);
         if (s_axi_awready_out && !ad)
         begin
            ad = 1;
            s_axi_awvalid_in <= 0;
         end
         if (s_axi_wready_out && !wd)
         begin
            wd = 1;
            s_axi_wvalid_in <= 0;
         end
      end
      do @(posedge clk_in); while (!s_axi_bvalid_out);
      r = s_axi_bresp_out;
   endtask

   task rd(input logic [7:0] a);
      s_axi_araddr_in <= a;
      s_axi_arvalid_in <= 1;
      do @(posedge clk_in); while (!s_axi_arready_out);
      s_axi_arvalid_in <= 0;
      do @(posedge clk_in); while (!s_axi_rvalid_out);
      d = s_axi_rdata_out;
      r = s_axi_rresp_out;
   endtask

   // Run pin change, then time for the synchroniser to follow
   task pin(input logic v);
      drive_run_enable_in <= v;
      repeat (6) @(posedge clk_in);
   endtask

   // Waits for {asleep, commands} with the expected pressure, then compares
   task wt(input logic [5:0] e);
      int k;
      k = 0;
      while ({comp_pressure_out, asleep_out, pump_command_out, bad} !==
         {cp, e, 1'b0} && k < 3000)
      begin
         @(posedge clk_in);
         k++;
      end
      chk({comp_pressure_out, asleep_out, pump_command_out, bad},
         {cp, e, 1'b0});
   endtask

   initial
   begin
      repeat (20) @(posedge clk_in);
      sys_rst_in <= 0;
      @(posedge clk_in);
      for (int i = 0; i < 12; i++)
      begin
         rd(8'(i * 4));
         chk(d, 32'h0);
         wr(8'(i * 4), 32'hFFFFFFFF);
         rd(8'(i * 4));
         chk(d, {16'h0000, M[i]});
      end
      rd(8'h40);
      chk(r, `PCC_RESP_SLVERR);
      wr(8'h40, 32'h1);
      chk(r, `PCC_RESP_SLVERR);
      // Configure while the run pin is low
      for (int i = 0; i < 13; i++)
         wr(A[i], {16'h0000, C[i]});
      drive_run_enable_in <= 1;
      output_frequency_in <= 16'h004B;
      wt(6'h01);
      output_frequency_in <= 16'h00C8;
      wt(6'h03);
      output_frequency_in <= 16'h004B;
      rd(8'h34);
      chk({d[0], irq_out}, 2'b11);
      wr(8'h38, 32'h1);
      rd(8'h34);
      chk({d[0], irq_out}, 2'b00);
      fault <= 5'h02;
      wt(6'h01);
      output_frequency_in <= 16'h00C8;
      wt(6'h05);
      fault <= 5'h00;
      output_frequency_in <= 16'h0014;
      wt(6'h01);
      wt(6'h20);
      pressure_feedback_in <= 16'h0064;
      output_frequency_in <= 16'h0028;
      wt(6'h01);
      pin(0);
      wr(8'h24, 32'h1);
      pin(1);
      wt(6'h02);
      pin(0);
      wr(8'h24, 32'h0);
      wr(8'h20, 32'h4000);
      pin(1);
      cp = 16'h03FC;
      wt(6'h02);
      pin(0);
      wr(8'h00, 32'h33);
      pin(1);
      cp = 16'h0078;
      wt(6'h02);
      fault <= 5'h02;
      wt(6'h04);
      // Frozen by the enable: no new pump, no new pressure
      ce_in <= 0;
      output_frequency_in <= 16'h00C8;
      repeat (40) @(posedge clk_in);
      chk({comp_pressure_out, asleep_out, pump_command_out}, {cp, 6'h04});
      ce_in <= 1;
      results();
   end
endmodule
